/* common/dlm_pkg.sv */
// Register map, field layout and reset values of the device lock and module standby block.
package dlm_pkg;
    // Register byte addresses on the APB.
    localparam logic [7:0] DLM_ADDR_PORT_LOCK = 8'h00;
    localparam logic [7:0] DLM_ADDR_STANDBY0 = 8'h04;
    localparam logic [7:0] DLM_ADDR_STANDBY1 = 8'h08;
    localparam logic [7:0] DLM_ADDR_BOOT_CTRL = 8'h0C;
    localparam logic [7:0] DLM_ADDR_ANALOG = 8'h10;
    localparam int DLM_ADDR_W = 8;

    // Port lock register.
    localparam int DLM_LOCK_BIT = 0;
    localparam logic DLM_LOCK_RESET = 1'b1;

    // Standby register 0: implemented bits and reset value.
    localparam logic [31:0] DLM_SR0_MASK = 32'hC7F6BB8F;
    localparam logic [31:0] DLM_SR0_RESET = 32'h00000100;

    // Standby register 1: implemented bits, reset value and cpu clock mode field.
    localparam logic [31:0] DLM_SR1_MASK = 32'h0000FFC7;
    localparam logic [31:0] DLM_SR1_RESET = 32'h00000001;
    localparam logic [31:0] DLM_SR1_CPU_CLOCK_MODE_MASK = 32'h00000007;
    localparam logic [3:0] DLM_STRB_FULL = 4'hF;

    // Boot control register: flash write enable bit, also its place in the boot config word.
    localparam int DLM_EWE_BIT = 0;
    localparam logic DLM_EWE_RESET = 1'b0;

    // Analog status register: two sticky error flags and the special output select field.
    localparam int DLM_CORE_ERR_BIT = 0;
    localparam int DLM_FLASH_ERR_BIT = 1;
    localparam int DLM_SEL_LSB = 4;
    localparam int DLM_SEL_MSB = 5;
    localparam logic [1:0] DLM_SEL_RESET = 2'h0;

    // Special output sources.
    localparam logic [1:0] DLM_SEL_PLL_LOCK = 2'h0;
    localparam logic [1:0] DLM_SEL_CORE_OVL = 2'h1;
    localparam logic [1:0] DLM_SEL_FLASH_OVL = 2'h2;

    // Indices of the pin inputs that pass the synchroniser.
    localparam int DLM_SYNC_N = 4;
    localparam int DLM_SYNC_CORE = 0;
    localparam int DLM_SYNC_FLASH = 1;
    localparam int DLM_SYNC_PLL = 2;
    localparam int DLM_SYNC_WAKE = 3;

    // Bus answer states.
    typedef enum logic [1:0]
    {
        DLM_BUS_IDLE = 2'b01,
        DLM_BUS_ACCESS = 2'b10
    } dlm_bus_e;
endpackage : dlm_pkg

/* hw/dlm_core.sv */
// Device lock, flash write enable, module standby registers and regulator error flags behind APB.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module dlm_core
    import dlm_pkg::*;
(
    // Clock and power-on reset.
    input wire logic I_MCLK,
    input wire logic I_RST,
    // Non power-on system reset, same clock domain.
    input wire logic I_SOFT_RST,
    // APB slave.
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [DLM_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [31:0] O_PRDATA,
    // Boot config word captured at reset exit.
    input wire logic I_BOOT_LOAD,
    input wire logic [31:0] I_BOOT_WORD,
    // Asynchronous pins: regulator overloads, pll lock, wake-up.
    input wire logic I_CORE_OVERLOAD,
    input wire logic I_FLASH_OVERLOAD,
    input wire logic I_PLL_LOCK,
    input wire logic I_WAKEUP,
    // Flash write requests from test bus and internal buses.
    input wire logic I_TEST_WR_REQ,
    input wire logic I_INT_WR_REQ,
    // Gated flash writes and lock state.
    output logic O_TEST_WR_ALLOW,
    output logic O_INT_WR_ALLOW,
    output logic O_TEST_PORT_ENABLE,
    output logic O_FLASH_WRITE_ENABLE,
    // Reset request and special output pin.
    output logic O_RESET_REQ,
    output logic O_SPECIAL_OUTPUT_PIN,
    // Module standby controls.
    output logic [31:0] O_STANDBY0,
    output logic [31:0] O_STANDBY1
);

    // Synchroniser stages for the pin inputs.
    logic [DLM_SYNC_N-1:0] sync1_q;
    logic [DLM_SYNC_N-1:0] sync2_q;
    logic [DLM_SYNC_N-1:0] pin_raw;

    // Register state.
    logic port_lock_bit_q;
    logic flash_write_enable_q;
    logic [31:0] module_standby_reg0_q;
    logic [31:0] module_standby_reg1_q;
    logic core_reg_error_flag_q;
    logic flash_supply_error_flag_q;
    logic [1:0] special_output_select_q;
    logic wake_prev_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    dlm_bus_e bus_state_q;

    // Decoded bus controls.
    logic wr_en;
    logic rd_setup;
    logic hit_lock;
    logic hit_sr0;
    logic hit_sr1;
    logic hit_boot;
    logic hit_analog;
    logic mapped;
    logic wake_pulse;
    logic [31:0] strb_mask;
    logic [31:0] sr1_mask;
    logic [31:0] rd_d;

    assign pin_raw[DLM_SYNC_CORE] = I_CORE_OVERLOAD;
    assign pin_raw[DLM_SYNC_FLASH] = I_FLASH_OVERLOAD;
    assign pin_raw[DLM_SYNC_PLL] = I_PLL_LOCK;
    assign pin_raw[DLM_SYNC_WAKE] = I_WAKEUP;

    // Two-flop synchronisers, one per pin; only the second stage feeds logic.
    genvar gi;
    generate
        for (gi = 0; gi < DLM_SYNC_N; gi++)
        begin : g_sync
            always_ff @(posedge I_MCLK or posedge I_RST)
            begin
                if (I_RST)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // Byte strobes widened to a bit mask.
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_strb
            assign strb_mask[gi*8 +: 8] = {8{I_PSTRB[gi]}};
        end
    endgenerate

    // Address decode; every access completes with no wait states.
    assign hit_lock = (I_PADDR == DLM_ADDR_PORT_LOCK);
    assign hit_sr0 = (I_PADDR == DLM_ADDR_STANDBY0);
    assign hit_sr1 = (I_PADDR == DLM_ADDR_STANDBY1);
    assign hit_boot = (I_PADDR == DLM_ADDR_BOOT_CTRL);
    assign hit_analog = (I_PADDR == DLM_ADDR_ANALOG);
    assign mapped = hit_lock | hit_sr0 | hit_sr1 | hit_boot | hit_analog;
    assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & mapped;
    assign rd_setup = I_PSEL & ~I_PENABLE;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = pslverr_q & I_PSEL & I_PENABLE & (bus_state_q == DLM_BUS_ACCESS);
    assign O_PRDATA = prdata_q;

    // Cpu clock mode is masked out unless all four strobes are set.
    assign sr1_mask = (I_PSTRB == DLM_STRB_FULL) ? DLM_SR1_MASK : (DLM_SR1_MASK & ~DLM_SR1_CPU_CLOCK_MODE_MASK);

    // Wake-up is taken on its rising edge after synchronisation.
    assign wake_pulse = sync2_q[DLM_SYNC_WAKE] & ~wake_prev_q;

    // Bus phase tracker, used to flag errors in the access cycle that follows a setup.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            bus_state_q <= DLM_BUS_IDLE;
        end
        else
        begin
            case (bus_state_q)
                DLM_BUS_IDLE: bus_state_q <= rd_setup ? DLM_BUS_ACCESS : DLM_BUS_IDLE;
                DLM_BUS_ACCESS: bus_state_q <= rd_setup ? DLM_BUS_ACCESS : DLM_BUS_IDLE;
                default: bus_state_q <= DLM_BUS_IDLE;
            endcase
        end
    end

    // Read mux; unused bits read zero.
    always_comb
    begin
        rd_d = 32'h00000000;
        if (hit_lock)
        begin
            rd_d[DLM_LOCK_BIT] = port_lock_bit_q;
        end
        else if (hit_sr0)
        begin
            rd_d = module_standby_reg0_q & DLM_SR0_MASK;
        end
        else if (hit_sr1)
        begin
            rd_d = module_standby_reg1_q & DLM_SR1_MASK;
        end
        else if (hit_boot)
        begin
            rd_d[DLM_EWE_BIT] = flash_write_enable_q;
        end
        else if (hit_analog)
        begin
            rd_d[DLM_CORE_ERR_BIT] = core_reg_error_flag_q;
            rd_d[DLM_FLASH_ERR_BIT] = flash_supply_error_flag_q;
            rd_d[DLM_SEL_MSB:DLM_SEL_LSB] = special_output_select_q;
        end
    end

    // Read data and error are captured in the setup cycle, so they come from flops in the access cycle.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (rd_setup)
        begin
            prdata_q <= I_PWRITE ? 32'h00000000 : rd_d;
            pslverr_q <= ~mapped;
        end
    end

    // Port lock survives a soft reset, so software can clear it and reboot through the test port.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            port_lock_bit_q <= DLM_LOCK_RESET;
            wake_prev_q <= 1'b0;
        end
        else
        begin
            wake_prev_q <= sync2_q[DLM_SYNC_WAKE];
            if (wake_pulse)
            begin
                port_lock_bit_q <= DLM_LOCK_RESET;
            end
            else if (wr_en && hit_lock && I_PSTRB[0])
            begin
                port_lock_bit_q <= I_PWDATA[DLM_LOCK_BIT];
            end
        end
    end

    // Test port is usable only while unlocked.
    assign O_TEST_PORT_ENABLE = ~port_lock_bit_q;

    // Flash write enable: cleared by any reset, loaded from the boot word, then software writable.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            flash_write_enable_q <= DLM_EWE_RESET;
        end
        else if (I_SOFT_RST)
        begin
            flash_write_enable_q <= DLM_EWE_RESET;
        end
        else if (I_BOOT_LOAD)
        begin
            flash_write_enable_q <= I_BOOT_WORD[DLM_EWE_BIT];
        end
        else if (wr_en && hit_boot && I_PSTRB[0])
        begin
            flash_write_enable_q <= I_PWDATA[DLM_EWE_BIT];
        end
    end

    // Every flash write or erase path is gated by the enable, external and internal alike.
    assign O_TEST_WR_ALLOW = I_TEST_WR_REQ & flash_write_enable_q & ~port_lock_bit_q;
    assign O_INT_WR_ALLOW = I_INT_WR_REQ & flash_write_enable_q;
    assign O_FLASH_WRITE_ENABLE = flash_write_enable_q;

    // Standby register 0: per-byte writes, unused bits forced to zero.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            module_standby_reg0_q <= DLM_SR0_RESET;
        end
        else if (I_SOFT_RST)
        begin
            module_standby_reg0_q <= DLM_SR0_RESET;
        end
        else if (wr_en && hit_sr0)
        begin
            // Byte lanes hold fields.
            module_standby_reg0_q <= ((module_standby_reg0_q & ~strb_mask) | (I_PWDATA & strb_mask))
                & DLM_SR0_MASK;
        end
    end

    // Standby register 1: cpu clock mode is protected against narrow writes.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            module_standby_reg1_q <= DLM_SR1_RESET;
        end
        else if (I_SOFT_RST)
        begin
            module_standby_reg1_q <= DLM_SR1_RESET;
        end
        else if (wr_en && hit_sr1)
        begin
            module_standby_reg1_q <= ((module_standby_reg1_q & ~(strb_mask & sr1_mask))
                | (I_PWDATA & strb_mask & sr1_mask)) & DLM_SR1_MASK;
        end
    end

    assign O_STANDBY0 = module_standby_reg0_q;
    assign O_STANDBY1 = module_standby_reg1_q;

    // Sticky error flags: overload sets, a one clears, and a set in the same cycle wins.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            core_reg_error_flag_q <= 1'b0;
            flash_supply_error_flag_q <= 1'b0;
        end
        else
        begin
            if (sync2_q[DLM_SYNC_CORE])
            begin
                core_reg_error_flag_q <= 1'b1;
            end
            else if (wr_en && hit_analog && I_PSTRB[0] && I_PWDATA[DLM_CORE_ERR_BIT])
            begin
                core_reg_error_flag_q <= 1'b0;
            end
            if (sync2_q[DLM_SYNC_FLASH])
            begin
                flash_supply_error_flag_q <= 1'b1;
            end
            else if (wr_en && hit_analog && I_PSTRB[0] && I_PWDATA[DLM_FLASH_ERR_BIT])
            begin
                flash_supply_error_flag_q <= 1'b0;
            end
        end
    end

    // Special output source select; kept over soft reset would hide the cause, so it clears.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            special_output_select_q <= DLM_SEL_RESET;
        end
        else if (I_SOFT_RST)
        begin
            special_output_select_q <= DLM_SEL_RESET;
        end
        else if (wr_en && hit_analog && I_PSTRB[0])
        begin
            special_output_select_q <= I_PWDATA[DLM_SEL_MSB:DLM_SEL_LSB];
        end
    end

    // Output pin from a flop so it carries no decode glitches.
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_SPECIAL_OUTPUT_PIN <= 1'b0;
        end
        else
        begin
            case (special_output_select_q)
                DLM_SEL_PLL_LOCK: O_SPECIAL_OUTPUT_PIN <= sync2_q[DLM_SYNC_PLL];
                DLM_SEL_CORE_OVL: O_SPECIAL_OUTPUT_PIN <= sync2_q[DLM_SYNC_CORE];
                DLM_SEL_FLASH_OVL: O_SPECIAL_OUTPUT_PIN <= sync2_q[DLM_SYNC_FLASH];
                default: O_SPECIAL_OUTPUT_PIN <= 1'b0;
            endcase
        end
    end

    // Overload requests a reset for as long as it lasts; the reset logic outside stretches it.
    assign O_RESET_REQ = sync2_q[DLM_SYNC_CORE] | sync2_q[DLM_SYNC_FLASH];

endmodule : dlm_core

/* testbench/dlm_core_properties.sv */
// Port checker of the lock, write enable, standby and overload behaviour.
`timescale 1ns/1ns
module dlm_core_checker
    import dlm_pkg::*;
(
    // Clock, resets and bus.
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_SOFT_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [DLM_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    // Boot word, pins and requests.
    input wire logic I_BOOT_LOAD,
    input wire logic [31:0] I_BOOT_WORD,
    input wire logic I_CORE_OVERLOAD,
    input wire logic I_WAKEUP,
    input wire logic I_TEST_WR_REQ,
    input wire logic I_INT_WR_REQ,
    // Watched outputs.
    input wire logic O_TEST_WR_ALLOW,
    input wire logic O_INT_WR_ALLOW,
    input wire logic O_TEST_PORT_ENABLE,
    input wire logic O_FLASH_WRITE_ENABLE,
    input wire logic O_RESET_REQ,
    input wire logic [31:0] O_STANDBY0,
    input wire logic [31:0] O_STANDBY1
);
    // One clock domain, so clock and reset are given once.
    default clocking dc @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    a_test_allow_gate: assert property (O_TEST_WR_ALLOW == (I_TEST_WR_REQ && O_FLASH_WRITE_ENABLE && O_TEST_PORT_ENABLE))
        else $error("test bus write allow wrong");
    a_int_allow_gate: assert property (O_INT_WR_ALLOW == (I_INT_WR_REQ && O_FLASH_WRITE_ENABLE))
        else $error("internal write allow wrong");
    a_boot_load_copy: assert property (I_BOOT_LOAD && !I_SOFT_RST |=> O_FLASH_WRITE_ENABLE == $past(I_BOOT_WORD[0]))
        else $error("write enable not loaded from boot word");
    a_soft_rst_clear: assert property (I_SOFT_RST |=> !O_FLASH_WRITE_ENABLE && O_STANDBY0 == 32'h00000100 && O_STANDBY1 == 32'h00000001)
        else $error("system reset left state");
    a_overload_reset: assert property (I_CORE_OVERLOAD [*3] |-> O_RESET_REQ)
        else $error("overload gave no reset");
    a_cpu_clock_mode_partial_keep: assert property (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == DLM_ADDR_STANDBY1 && I_PSTRB != 4'hF && !I_SOFT_RST |=> $stable(O_STANDBY1[2:0]))
        else $error("cpu mode changed by narrow write");
    a_unused_zero: assert property ((O_STANDBY0 & 32'h38094470) == 32'h0 && (O_STANDBY1 & 32'hFFFF0038) == 32'h0)
        else $error("unused standby bit set");
    a_wake_relock: assert property ($rose(I_WAKEUP) |-> ##[1:5] !O_TEST_PORT_ENABLE)
        else $error("wake-up did not lock");
    a_sr0_write: assert property (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == DLM_ADDR_STANDBY0 && I_PSTRB == 4'hF && !I_SOFT_RST |=> O_STANDBY0 == ($past(I_PWDATA) & 32'hC7F6BB8F))
        else $error("standby0 write wrong");

    // Main scenarios reached.
    c_boot: cover property (I_BOOT_LOAD && I_BOOT_WORD[0]);
    c_wake: cover property ($rose(I_WAKEUP));
    c_overload: cover property (O_RESET_REQ);
endmodule : dlm_core_checker

/* testbench/dlm_core_tb.sv */
// Self-checking testbench of the lock, write enable, standby and regulator flag block.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module dlm_core_tb
    import dlm_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic soft_rst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, boot_load = 1'b0;
    logic core_ovl = 1'b0, flash_ovl = 1'b0, wake = 1'b0, test_req = 1'b0, int_req = 1'b0, pll = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, boot_word = 32'h0, rdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, serr, pslverr, test_allow, int_allow, port_en, fwe, reset_req, spec_pin;
    logic [31:0] prdata, stby0, stby1;
    int err_total = 0;
    int checks = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    dlm_core dlm_core_i (.I_MCLK(clk), .I_RST(rst), .I_SOFT_RST(soft_rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_PRDATA(prdata), .I_BOOT_LOAD(boot_load), .I_BOOT_WORD(boot_word),
        .I_CORE_OVERLOAD(core_ovl), .I_FLASH_OVERLOAD(flash_ovl), .I_PLL_LOCK(pll), .I_WAKEUP(wake),
        .I_TEST_WR_REQ(test_req), .I_INT_WR_REQ(int_req), .O_TEST_WR_ALLOW(test_allow), .O_INT_WR_ALLOW(int_allow),
        .O_TEST_PORT_ENABLE(port_en), .O_FLASH_WRITE_ENABLE(fwe), .O_RESET_REQ(reset_req),
        .O_SPECIAL_OUTPUT_PIN(spec_pin), .O_STANDBY0(stby0), .O_STANDBY1(stby1));

    // One APB transfer; answer taken at the edge where pready is seen, outputs read mid-cycle after.
    // The master waits as long as the slave needs; only the watchdog ends a hang.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0, 4'hF);
        `CHK(nm, e, rdata)
    endtask : rd

    // Drives the asynchronous pins and waits past the synchroniser delay.
    task automatic pins(input logic c, input logic f, input logic w);
        @(posedge clk);
        core_ovl <= c;
        flash_ovl <= f;
        wake <= w;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask : pins

    // One-cycle reset pulse: power-on reset when por is set, system reset otherwise.
    task automatic pulse(input logic por);
        @(posedge clk);
        if (por)
            rst <= 1'b1;
        else
            soft_rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        soft_rst <= 1'b0;
        @(negedge clk);
    endtask : pulse

    // One-cycle boot load with the captured word held alongside it.
    task automatic boot(input logic [31:0] w);
        @(posedge clk);
        boot_word <= w;
        boot_load <= 1'b1;
        @(posedge clk);
        boot_load <= 1'b0;
        @(negedge clk);
    endtask : boot

    task automatic t_reset_vals();
        rd(DLM_ADDR_PORT_LOCK, 32'h1, "lock");
        rd(DLM_ADDR_STANDBY0, 32'h00000100, "sr0");
        rd(DLM_ADDR_STANDBY1, 32'h00000001, "sr1");
        rd(DLM_ADDR_BOOT_CTRL, 32'h0, "fwe");
        `CHK("port_en", 1'b0, port_en)
        $display("reset values done");
    endtask : t_reset_vals

    task automatic t_gate();
        wr(DLM_ADDR_PORT_LOCK, 32'hFFFFFFFE);
        rd(DLM_ADDR_PORT_LOCK, 32'h0, "unlock");
        `CHK("port_en", 1'b1, port_en)
        @(posedge clk);
        test_req <= 1'b1;
        int_req <= 1'b1;
        rd(DLM_ADDR_BOOT_CTRL, 32'h0, "fwe0");
        `CHK("t_allow", 1'b0, test_allow)
        `CHK("i_allow", 1'b0, int_allow)
        wr(DLM_ADDR_BOOT_CTRL, 32'h1);
        `CHK("t_allow1", 1'b1, test_allow)
        wr(DLM_ADDR_PORT_LOCK, 32'h1);
        `CHK("t_allow lk", 1'b0, test_allow)
        `CHK("i_allow lk", 1'b1, int_allow)
        boot(32'hFFFFFFFE);
        `CHK("boot0", 1'b0, fwe)
        boot(32'h1);
        `CHK("boot1", 1'b1, fwe)
        $display("write gating done");
    endtask : t_gate

    task automatic t_standby();
        wr(DLM_ADDR_STANDBY0, 32'hFFFFFFFF);
        rd(DLM_ADDR_STANDBY0, 32'hC7F6BB8F, "sr0 ones");
        `CHK("stby0", 32'hC7F6BB8F, stby0)
        wr(DLM_ADDR_STANDBY0, 32'h0);
        apb(1'b1, DLM_ADDR_STANDBY0, 32'hFFFFFFFF, 4'h2);
        rd(DLM_ADDR_STANDBY0, 32'h0000BB00, "sr0 lane");
        apb(1'b1, DLM_ADDR_STANDBY1, 32'hFFFFFFFF, 4'h3);
        rd(DLM_ADDR_STANDBY1, 32'h0000FFC1, "sr1 narrow");
        wr(DLM_ADDR_STANDBY1, 32'hFFFFFFF8);
        rd(DLM_ADDR_STANDBY1, 32'h0000FFC0, "sr1 full");
        `CHK("stby1", 32'h0000FFC0, stby1)
        $display("standby done");
    endtask : t_standby

    task automatic t_flags();
        wr(DLM_ADDR_ANALOG, 32'h10);
        pins(1'b1, 1'b0, 1'b0);
        `CHK("rst_req", 1'b1, reset_req)
        `CHK("spec", 1'b1, spec_pin)
        wr(DLM_ADDR_ANALOG, 32'h11);
        rd(DLM_ADDR_ANALOG, 32'h11, "core held");
        pins(1'b0, 1'b0, 1'b0);
        `CHK("rst_req0", 1'b0, reset_req)
        wr(DLM_ADDR_ANALOG, 32'h20);
        rd(DLM_ADDR_ANALOG, 32'h21, "w0 no-op");
        pins(1'b0, 1'b1, 1'b0);
        `CHK("spec f", 1'b1, spec_pin)
        pins(1'b0, 1'b0, 1'b0);
        rd(DLM_ADDR_ANALOG, 32'h23, "both");
        wr(DLM_ADDR_ANALOG, 32'h03);
        rd(DLM_ADDR_ANALOG, 32'h0, "cleared");
        @(posedge clk);
        pll <= 1'b1;
        pins(1'b0, 1'b0, 1'b0);
        `CHK("spec pll", 1'b1, spec_pin)
        wr(DLM_ADDR_ANALOG, 32'h30);
        pins(1'b0, 1'b0, 1'b0);
        `CHK("spec off", 1'b0, spec_pin)
        @(posedge clk);
        pll <= 1'b0;
        $display("flags done");
    endtask : t_flags

    task automatic t_resets();
        wr(DLM_ADDR_PORT_LOCK, 32'h0);
        pins(1'b0, 1'b0, 1'b1);
        rd(DLM_ADDR_PORT_LOCK, 32'h1, "wake");
        pins(1'b0, 1'b0, 1'b0);
        wr(DLM_ADDR_PORT_LOCK, 32'h0);
        wr(DLM_ADDR_STANDBY0, 32'h00000080);
        pulse(1'b0);
        `CHK("soft fwe", 1'b0, fwe)
        `CHK("soft sr0", 32'h00000100, stby0)
        `CHK("soft lock", 1'b1, port_en)
        pulse(1'b1);
        `CHK("por lock", 1'b0, port_en)
        rd(DLM_ADDR_STANDBY0, 32'h00000100, "sr0 por");
        `CHK("ok serr", 1'b0, serr)
        apb(1'b0, 8'h20, 32'h0, 4'hF);
        `CHK("bad rd", 32'h0, rdata)
        `CHK("bad rd serr", 1'b1, serr)
        apb(1'b1, 8'h20, 32'hFFFFFFFF, 4'hF);
        `CHK("bad wr", 1'b1, serr)
        $display("resets done");
    endtask : t_resets

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // Main sequence after six cycles of power-on reset.
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals();
        t_gate();
        t_standby();
        t_flags();
        t_resets();
        final_report();
    end

    // Watchdog: the tests need well under 2000 cycles.
    initial
    begin
        #100000;
        err_total++;
        final_report();
    end
endmodule : dlm_core_tb

// Attaches the port checker to the block.
bind dlm_core dlm_core_checker dlm_core_checker_i (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_SOFT_RST(I_SOFT_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .I_PSTRB(I_PSTRB), .I_BOOT_LOAD(I_BOOT_LOAD), .I_BOOT_WORD(I_BOOT_WORD), .I_CORE_OVERLOAD(I_CORE_OVERLOAD),
    .I_WAKEUP(I_WAKEUP), .I_TEST_WR_REQ(I_TEST_WR_REQ), .I_INT_WR_REQ(I_INT_WR_REQ),
    .O_TEST_WR_ALLOW(O_TEST_WR_ALLOW), .O_INT_WR_ALLOW(O_INT_WR_ALLOW), .O_TEST_PORT_ENABLE(O_TEST_PORT_ENABLE),
    .O_FLASH_WRITE_ENABLE(O_FLASH_WRITE_ENABLE), .O_RESET_REQ(O_RESET_REQ), .O_STANDBY0(O_STANDBY0),
    .O_STANDBY1(O_STANDBY1));
